// ===== verilog/cku_pkg.sv
// package for the customer key unlock block: map, fields, resets, carriers
package cku_pkg;

  ////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_SETS  = 3;
  localparam int KEY_WORDS = 8;
  localparam int WORD_W    = 32;
  localparam int KEY_W     = 256;
  localparam int ADDR_W    = 12;
  localparam int IRQ_W     = 6;

  ////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_KEY_A    = 12'h060;
  localparam logic [11:0] OFS_KEY_B    = 12'h080;
  localparam logic [11:0] OFS_KEY_C    = 12'h0c0;
  localparam logic [11:0] OFS_STATUS   = 12'h100;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h104;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h108;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int POS_LOCK_A = 4;
  localparam int POS_LOCK_B = 5;
  localparam int POS_LOCK_C = 6;
  localparam int POS_EV_DONE = 0;  // bits 2:0, one per set a, b, c
  localparam int POS_EV_ERR  = 3;  // bits 5:3, one per set a, b, c

  ////////////////////////////////////////////////////////////////////////
  // reset values and bus constants
  localparam logic [31:0] RST_KEY_WORD = 32'h0000_0000;
  localparam logic [2:0]  RST_LOCKED   = 3'h7;
  localparam logic [5:0]  RST_IRQ      = 6'h00;
  localparam logic [3:0]  FULL_STRB    = 4'hf;
  localparam logic [2:0]  LAST_WORD    = 3'h7;

  typedef enum logic [1:0] {
    SET_A = 2'b00,
    SET_B = 2'b01,
    SET_C = 2'b10
  } cku_set_e;

  // apb request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } cku_apb_req_s;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cku_apb_rsp_s;

  // address decode result
  typedef struct packed {
    logic       key_hit;
    logic [1:0] set;
    logic [2:0] word;
  } cku_dec_s;

endpackage

// ===== verilog/cku_top.sv
// customer key unlock: three key word sets, apb slave, lock status, irq
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module cku_top (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire cku_pkg::cku_apb_req_s apb_req,
  output var  cku_pkg::cku_apb_rsp_s apb_rsp,
  input  wire logic [255:0]         ref_key_a,
  input  wire logic [255:0]         ref_key_b,
  input  wire logic [255:0]         ref_key_c,
  output logic                      cust_a_locked,
  output logic                      cust_b_locked,
  output logic                      cust_c_locked,
  output logic                      irq
);
  import cku_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks: the decode assumes these shapes
  if (KEY_WORDS != 8 || KEY_W != KEY_WORDS * WORD_W || ADDR_W < 9) begin : g_chk
    $error("cku_top: unsupported key or address shape");
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] key           [NUM_SETS][KEY_WORDS];
  logic [31:0] next_key      [NUM_SETS][KEY_WORDS];
  logic [2:0]  seq_idx       [NUM_SETS];
  logic [2:0]  next_seq_idx  [NUM_SETS];
  logic        seq_bad       [NUM_SETS];
  logic        next_seq_bad  [NUM_SETS];
  logic [2:0]  locked;
  logic [2:0]  next_locked;
  logic [5:0]  irq_stat;
  logic [5:0]  next_irq_stat;
  logic [5:0]  irq_mask;
  logic [5:0]  next_irq_mask;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        slverr;
  logic        next_slverr;

  logic [255:0] ref_key [NUM_SETS];
  cku_dec_s     dec;
  logic         setup_ph;
  logic         wr_ok;

  ////////////////////////////////////////////////////////////////////////
  // address decode, shared by read and write paths
  function automatic cku_dec_s decode(input logic [ADDR_W-1:0] a);
    cku_dec_s d;
    d = '0;
    d.word = a[4:2];
    if (a[1:0] == 2'b00) begin
      if (a[ADDR_W-1:5] == OFS_KEY_A[ADDR_W-1:5]) begin
        d.key_hit = 1'b1;
        d.set = SET_A;
      end else if (a[ADDR_W-1:5] == OFS_KEY_B[ADDR_W-1:5]) begin
        d.key_hit = 1'b1;
        d.set = SET_B;
      end else if (a[ADDR_W-1:5] == OFS_KEY_C[ADDR_W-1:5]) begin
        d.key_hit = 1'b1;
        d.set = SET_C;
      end
    end
    return d;
  endfunction

  // references are only ever read here, never written back
  assign ref_key[0] = ref_key_a;
  assign ref_key[1] = ref_key_b;
  assign ref_key[2] = ref_key_c;

  assign dec      = decode(apb_req.paddr);
  assign setup_ph = apb_req.psel & ~apb_req.penable;
  // write lands at the access edge unless the setup check flagged an error
  assign wr_ok    = apb_req.psel & apb_req.penable & apb_req.pwrite & ~slverr;

  ////////////////////////////////////////////////////////////////////////
  // bus answer: read data and error are sampled in setup, so no wait state
  always_comb begin
    next_rdata  = rdata;
    next_slverr = slverr;
    if (setup_ph) begin
      next_rdata  = 32'h0000_0000;
      next_slverr = 1'b0;
      if (dec.key_hit) begin
        next_rdata = key[dec.set][dec.word];
        // byte or halfword writes refused as a whole
        next_slverr = apb_req.pwrite && (apb_req.pstrb != FULL_STRB);
      end else if (apb_req.paddr == OFS_STATUS) begin
        next_rdata[POS_LOCK_A] = locked[0];
        next_rdata[POS_LOCK_B] = locked[1];
        next_rdata[POS_LOCK_C] = locked[2];
        next_slverr = apb_req.pwrite;  // status is read only
      end else if (apb_req.paddr == OFS_IRQ_STAT) begin
        next_rdata[IRQ_W-1:0] = irq_stat;
      end else if (apb_req.paddr == OFS_IRQ_MASK) begin
        next_rdata[IRQ_W-1:0] = irq_mask;
      end else begin
        next_slverr = 1'b1;  // unmapped
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata  <= 32'h0000_0000;
      slverr <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      slverr <= next_slverr;
    end
  end

  assign apb_rsp.prdata  = rdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = slverr;

  ////////////////////////////////////////////////////////////////////////
  // key words, write order tracking and compare
  always_comb begin
    logic [255:0] cand;
    logic [5:0]   ev;
    logic         in_order;
    cand = '0;
    ev = '0;
    in_order = 1'b0;
    next_key     = key;
    next_seq_idx = seq_idx;
    next_seq_bad = seq_bad;
    next_locked  = locked;
    for (int s = 0; s < NUM_SETS; s++) begin
      if (wr_ok && dec.key_hit && dec.set == s[1:0]) begin
        next_key[s][dec.word] = apb_req.pwdata;
        in_order = !seq_bad[s] && (dec.word == seq_idx[s]);
        if (dec.word == LAST_WORD) begin
          // word n sits at bits 32n+31:32n, word 7 taken from the bus
          for (int j = 0; j < KEY_WORDS - 1; j++) begin
            cand[j*WORD_W +: WORD_W] = key[s][j];
          end
          cand[KEY_W-1 -: WORD_W] = apb_req.pwdata;
          // a broken sequence never unlocks, whatever the words hold
          next_locked[s] = !(in_order && cand == ref_key[s]);
          ev[POS_EV_DONE + s] = 1'b1;
          ev[POS_EV_ERR + s]  = !in_order;
          next_seq_idx[s] = 3'h0;
          next_seq_bad[s] = 1'b0;
        end else if (dec.word == 3'h0) begin
          // word 0 always starts a fresh sequence
          next_seq_idx[s] = 3'h1;
          next_seq_bad[s] = 1'b0;
        end else if (in_order) begin
          next_seq_idx[s] = dec.word + 3'h1;
        end else begin
          next_seq_bad[s] = 1'b1;
          ev[POS_EV_ERR + s] = !seq_bad[s];
        end
      end
    end
    // interrupt status: write one to clear, a new event wins over the clear
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    if (wr_ok && apb_req.paddr == OFS_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~apb_req.pwdata[IRQ_W-1:0];
    end
    if (wr_ok && apb_req.paddr == OFS_IRQ_MASK) begin
      next_irq_mask = apb_req.pwdata[IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | ev;
  end

  // all key words clear to zero; sets start locked
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        for (int j = 0; j < KEY_WORDS; j++) begin
          key[s][j] <= RST_KEY_WORD;
        end
        seq_idx[s] <= 3'h0;
        seq_bad[s] <= 1'b0;
      end
      locked   <= RST_LOCKED;
      irq_stat <= RST_IRQ;
      irq_mask <= RST_IRQ;
    end else begin
      key      <= next_key;
      seq_idx  <= next_seq_idx;
      seq_bad  <= next_seq_bad;
      locked   <= next_locked;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign cust_a_locked = locked[0];
  assign cust_b_locked = locked[1];
  assign cust_c_locked = locked[2];
  assign irq           = |(irq_stat & irq_mask);

endmodule

`default_nettype wire

// ===== dv/cku_top_props.sv
// checker for the customer key unlock block
`timescale 1ns/1ps
`default_nettype none
module cku_top_props (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire cku_pkg::cku_apb_req_s apb_req,
  input wire cku_pkg::cku_apb_rsp_s apb_rsp,
  input wire logic [255:0]          ref_key_a,
  input wire logic [255:0]          ref_key_b,
  input wire logic [255:0]          ref_key_c,
  input wire logic                  cust_a_locked,
  input wire logic                  cust_b_locked,
  input wire logic                  cust_c_locked,
  input wire logic                  irq
);
  import cku_pkg::*;
  logic [11:0] a;
  logic        su, wa, k, w7, wka, wkb, wkc;
  // bus phase and key window qualifiers
  assign a   = apb_req.paddr;
  assign su  = apb_req.psel && !apb_req.penable;
  assign wa  = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign k   = (a >= 12'h060 && a < 12'h0a0) || (a >= 12'h0c0 && a < 12'h0e0);
  assign w7  = wa && k && a[4:0] == 5'h1c;
  assign wka = wa && a == 12'h07c && apb_req.pwdata == ref_key_a[255:224];
  assign wkb = wa && a == 12'h09c && apb_req.pwdata == ref_key_b[255:224];
  assign wkc = wa && a == 12'h0dc && apb_req.pwdata == ref_key_c[255:224];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  a_unlock_a: assert property ($fell(cust_a_locked) |-> $past(wka)) else $error("key a unlocked wrongly");
  b_unlock_a: assert property ($fell(cust_b_locked) |-> $past(wkb)) else $error("key b unlocked wrongly");
  c_unlock_a: assert property ($fell(cust_c_locked) |-> $past(wkc)) else $error("key c unlocked wrongly");
  lock_change_a: assert property ($changed({cust_c_locked, cust_b_locked, cust_a_locked}) |-> $past(w7))
    else $error("lock moved without word 7");
  part_strobe_a: assert property (su && apb_req.pwrite && k && apb_req.pstrb != FULL_STRB |=> apb_rsp.pslverr)
    else $error("partial key write accepted");
  misaligned_a: assert property (su && !apb_req.pwrite && a[1:0] != 2'b00 |=> apb_rsp.pslverr && apb_rsp.prdata == 0)
    else $error("misaligned read accepted");
  status_read_a: assert property (su && !apb_req.pwrite && a == OFS_STATUS |=>
    apb_rsp.prdata == {25'h0, $past(cust_c_locked), $past(cust_b_locked), $past(cust_a_locked), 4'h0})
    else $error("status read wrong");
  reset_state_a: assert property (disable iff (1'b0) rst |=> cust_a_locked && cust_b_locked && cust_c_locked
    && !irq && !apb_rsp.pslverr) else $error("reset state wrong");
endmodule
bind cku_top cku_top_props u_props (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .ref_key_a(ref_key_a), .ref_key_b(ref_key_b), .ref_key_c(ref_key_c), .cust_a_locked(cust_a_locked),
  .cust_b_locked(cust_b_locked), .cust_c_locked(cust_c_locked), .irq(irq));
`default_nettype wire

// ===== dv/cku_top_bench.sv
// self-checking bench for the customer key unlock block
`timescale 1ns/1ps
`default_nettype none
module cku_top_bench;
  import cku_pkg::*;
  logic         sys_clk, rst, irq, er;
  cku_apb_req_s req;
  cku_apb_rsp_s rsp;
  logic [255:0] rk [3];
  logic [2:0]   lk, ex;
  logic [31:0]  rd, lf;
  int           n_fail, checks_done;
  cku_top u_dut (.sys_clk(sys_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .ref_key_a(rk[0]),
    .ref_key_b(rk[1]), .ref_key_c(rk[2]), .cust_a_locked(lk[0]), .cust_b_locked(lk[1]),
    .cust_c_locked(lk[2]), .irq(irq));
  // 50 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [11:0] ka(int s, int n);
    return (s == 0 ? OFS_KEY_A : s == 1 ? OFS_KEY_B : OFS_KEY_C) + 12'(4 * n);
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle edge after it keeps drives one per time step
  task automatic apb(logic w, logic [11:0] ad, logic [31:0] d, logic [3:0] s);
    int i;
    req <= '{1'b1, 1'b0, w, ad, d, s};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 50);
    if (i == 50) begin
      n_fail++;
      stop_test();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge sys_clk);
  endtask
  // words 0..7 in order, bit 0 of one word flipped or one word skipped on request
  task automatic load(int s, int flip, int skip);
    for (int n = 0; n < 8; n++)
      if (n != skip) apb(1'b1, ka(s, n), rk[s][32*n +: 32] ^ 32'(n == flip), FULL_STRB);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    rst = 1'b1;
    n_fail = 0;
    checks_done = 0;
    lf = 32'h0000_b992;
    for (int n = 0; n < 24; n++) begin
      lf = nxt(lf);
      rk[n / 8][32*(n % 8) +: 32] = lf;
    end
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int n = 0; n < 24; n++) begin
      apb(1'b0, ka(n / 8, n % 8), '0, FULL_STRB);
      chk(rd, RST_KEY_WORD);
    end
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_003f, FULL_STRB);
    ex = 3'h7;
    for (int s = 0; s < 3; s++) begin
      load(s, 8, 8);
      ex[s] = 1'b0;
      chk(lk, ex);
      chk(irq, 1);
      lf = nxt(lf);
      apb(1'b0, ka(s, lf % 8), '0, FULL_STRB);
      chk(rd, rk[s][32*(lf % 8) +: 32]);
      apb(1'b0, OFS_STATUS, '0, FULL_STRB);
      chk(rd, {25'h0, ex, 4'h0});
      load(s, lf % 8, 8);
      ex[s] = 1'b1;
      chk(lk, ex);
      load(s, 8, 8);
      load(s, 8, 1 + lf % 6);
      chk(lk, ex);
      apb(1'b0, OFS_IRQ_STAT, '0, FULL_STRB);
      chk(rd[3 + s], 1);
    end
    apb(1'b1, OFS_IRQ_MASK, '0, FULL_STRB);
    chk(irq, 0);
    apb(1'b1, OFS_IRQ_STAT, 32'h0000_003f, FULL_STRB);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_003f, FULL_STRB);
    chk(irq, 0);
    apb(1'b1, ka(2, 3), 32'h0000_0000, 4'h3);
    chk(er, 1);
    apb(1'b0, ka(2, 3), '0, FULL_STRB);
    chk(rd, rk[2][127:96]);
    apb(1'b0, 12'h202, '0, FULL_STRB);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, OFS_STATUS, '0, FULL_STRB);
    chk(er, 1);
    stop_test();
  end
endmodule
`default_nettype wire
